// [design/fhr_defs.vh]
// constants for the floppy host-side register bank
`ifndef FHR_DEFS_VH
`define FHR_DEFS_VH
`define FHR_A_DATA 3'h0
`define FHR_A_MSTAT 3'h1
`define FHR_A_DIAG 3'h2
`define FHR_A_RATE 3'h3
`define FHR_A_CFG 3'h4
`define FHR_A_RPSEL 3'h5
`define FHR_A_ST0 3'h6
`define FHR_A_CTRL 3'h7
`define FHR_CFG_FDIS 0
`define FHR_CFG_LOCK 1
`define FHR_CFG_THR_LO 2
`define FHR_CFG_THR_HI 5
`define FHR_CFG_BURST 6
`define FHR_CFG_RDOFF 7
`define FHR_CFG_WROFF 8
`define FHR_CFG_LAY_LO 9
`define FHR_CFG_LAY_HI 10
`define FHR_CTRL_SRST 0
`define FHR_RATE_RST 2'h2
`define FHR_RATE_NO_PRECOMP_FLAG 2
`define FHR_THR_RST 4'h0
`define FHR_LAY_AT 2'h0
`define FHR_LAY_SEC 2'h1
`define FHR_LAY_THIRD 2'h2
`define FHR_PH_CMD 2'h0
`define FHR_PH_EXEC 2'h1
`define FHR_PH_RES 2'h2
`define FHR_DEPTH 16
`define FHR_CNT_W 5
`define FHR_GAP_NS 350
`define FHR_CLK_NS 40
`endif

// [design/fhr_regs.v]
// floppy host-side data fifo, diagnostic, rate and status registers
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fhr_defs.vh"
// Overview of operation
// R1: host polls flags before each command write
// R2: host polls flags before each result read
// R3: fifo only in execution phase, else bypass
// R4: soft reset keeps fifo enable when locked
// R5: hardware reset: fifo off, threshold zero
// R6: burst mode holds request until done
// R7: non-burst drops request 350 ns between bytes
// R8: fifo disable separately for reads, writes
// R9: host answers within threshold-based service time
// R10: disabled fifo acts as threshold zero
// R11: first layout: disk changed on bit 7
// R12: diagnostic ignores soft reset
// R13: second layout: ones, rate, density bit
// R14: third layout: inverted change, dma, precomp
// R15: rate control: hard reset 250 kbps
// R16: rate follows latest rate write
// R17: no-precomp flag kept, readable on diagnostic
// R18: status byte only in result phase
// R19: status bits 7-6 termination code
// R20: bit 5 seek done, bit 4 fault
// R21: bit 2 head, bits 1-0 drive
// R22: direction flag 0 write, 1 read
// R23: threshold 0-15, soft reset default unless locked
// R24: reserved rate control bits ignored
module fhr_regs (
  input wire mclk,
  input wire sys_rst,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [1:0] core_phase,
  input wire core_dir,
  input wire core_push,
  input wire [7:0] core_push_data,
  input wire core_pop,
  output reg [7:0] core_pop_data_r,
  output reg core_pop_valid_r,
  output reg core_room_r,
  input wire [1:0] termination_code,
  input wire seek_complete,
  input wire equipment_fault,
  input wire head_select_pin,
  input wire [1:0] drive_code,
  input wire disk_changed_input,
  input wire dma_gate_enable,
  output reg [1:0] rate_select_r,
  output reg no_precomp_flag_r,
  output reg fifo_enable_r,
  output reg [3:0] fifo_trigger_level_r,
  output reg dma_request_line_r,
  output reg [7:0] st0_byte_r
);

  // gap rounded up to whole clock cycles
  localparam integer GAP_INT =
    (`FHR_GAP_NS + `FHR_CLK_NS - 1) / `FHR_CLK_NS;
  localparam [4:0] GAP_CYC = GAP_INT[4:0];

  function fhr_low_rate;
    input [1:0] rs;
    begin
      fhr_low_rate = (rs == 2'h1) || (rs == 2'h2);
    end
  endfunction

  // accepted access to one word address
  function fhr_hit;
    input en;
    input [2:0] a;
    input [2:0] want;
    begin
      fhr_hit = en && (a == want);
    end
  endfunction

  reg [7:0] mem_r [0:`FHR_DEPTH-1];
  reg [3:0] rdp_r;
  reg [3:0] wrp_r;
  reg [4:0] cnt_r;
  reg [4:0] cnt_nxt;
  reg [10:0] cfg_r;
  reg req_on_r;
  reg [4:0] gap_r;
  reg [31:0] rd_nxt;
  reg [7:0] diag_v;
  reg push;
  reg pop;
  reg [7:0] push_byte;
  reg soft_rst;
  reg req_cond;
  reg req_nxt;

  wire host_wr;
  wire host_rd;
  wire wr_data;
  wire wr_cfg;
  wire wr_rate;
  wire wr_rpsel;
  wire wr_ctrl;
  wire rd_data;
  wire fdis;
  wire lock;
  wire [3:0] thr;
  wire burst;
  wire [1:0] lay;
  wire exec;
  wire res_ph;
  wire dir_off;
  wire use_fifo;
  wire [4:0] cap;
  wire [3:0] thr_eff;
  wire [4:0] thr1;
  wire [4:0] room;
  wire [1:0] pin_in;
  wire [1:0] sync_q;
  wire dsk_chg;
  wire hd_pin;
  wire [7:0] st0_v;
  wire request_for_master;
  wire xfer;

  // bus strobes, live in the acknowledge cycle only
  assign host_wr = avs_write && !avs_waitrequest;
  assign host_rd = avs_read && !avs_waitrequest;
  assign wr_data = fhr_hit(host_wr, avs_address, `FHR_A_DATA);
  assign wr_cfg = fhr_hit(host_wr, avs_address, `FHR_A_CFG);
  assign wr_rate = fhr_hit(host_wr, avs_address, `FHR_A_RATE);
  assign wr_rpsel = fhr_hit(host_wr, avs_address, `FHR_A_RPSEL);
  assign wr_ctrl = fhr_hit(host_wr, avs_address, `FHR_A_CTRL);
  assign rd_data = fhr_hit(host_rd, avs_address, `FHR_A_DATA);
  assign fdis = cfg_r[`FHR_CFG_FDIS];
  assign lock = cfg_r[`FHR_CFG_LOCK];
  assign thr = cfg_r[`FHR_CFG_THR_HI:`FHR_CFG_THR_LO];
  assign burst = cfg_r[`FHR_CFG_BURST];
  assign lay = cfg_r[`FHR_CFG_LAY_HI:`FHR_CFG_LAY_LO];
  assign exec = (core_phase == `FHR_PH_EXEC);
  assign res_ph = (core_phase == `FHR_PH_RES);
  assign dir_off = core_dir ? cfg_r[`FHR_CFG_RDOFF] : cfg_r[`FHR_CFG_WROFF];
  // full depth only in execution phase
  assign use_fifo = !fdis && exec && !dir_off; // R3 R8
  assign cap = use_fifo ? 5'd16 : 5'd1; // R3
  assign thr_eff = use_fifo ? thr : 4'h0; // R10
  assign thr1 = {1'b0, thr_eff} + 5'd1;
  assign room = cap - cnt_r;
  assign pin_in = {head_select_pin, disk_changed_input};
  assign dsk_chg = sync_q[0];
  assign hd_pin = sync_q[1];
  assign st0_v = {termination_code, seek_complete,
                  equipment_fault, 1'b0, hd_pin, drive_code};
  assign request_for_master = (core_phase == `FHR_PH_CMD) ? (cnt_r == 5'd0) :
               res_ph ? (cnt_r != 5'd0) :
               dma_request_line_r;
  // byte moved on the host side of the fifo
  assign xfer = (core_dir ? pop : push) && exec;

  // pin inputs: two flip-flops per pin
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      reg s1_r;
      reg s2_r;
      always @(posedge mclk) begin
        if (sys_rst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else begin
          s1_r <= pin_in[gi];
          s2_r <= s1_r;
        end
      end
      assign sync_q[gi] = s2_r;
    end
  endgenerate

  // fifo push/pop sources follow direction
  always @* begin
    soft_rst = wr_ctrl && avs_writedata[`FHR_CTRL_SRST];
    if (core_dir) begin
      push = core_push && (cnt_r < cap);
      push_byte = core_push_data;
      pop = rd_data && (cnt_r != 5'd0);
    end else begin
      push = wr_data && (cnt_r < cap);
      push_byte = avs_writedata[7:0];
      pop = core_pop && (cnt_r != 5'd0);
    end
    if (soft_rst)
      cnt_nxt = 5'd0;
    else
      cnt_nxt = cnt_r + {4'h0, push} - {4'h0, pop};
  end

  always @(posedge mclk) begin
    if (push)
      mem_r[wrp_r] <= push_byte;
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      rdp_r <= 4'h0;
      wrp_r <= 4'h0;
      cnt_r <= 5'd0;
      core_pop_data_r <= 8'h00;
      core_pop_valid_r <= 1'b0;
      core_room_r <= 1'b1;
    end else begin
      core_pop_valid_r <= pop && !core_dir;
      if (pop && !core_dir)
        core_pop_data_r <= mem_r[rdp_r];
      if (soft_rst) begin
        rdp_r <= 4'h0;
        wrp_r <= 4'h0;
      end else begin
        if (push)
          wrp_r <= wrp_r + 4'h1;
        if (pop)
          rdp_r <= rdp_r + 4'h1;
      end
      cnt_r <= cnt_nxt;
      core_room_r <= cnt_nxt < cap;
    end
  end

  // configuration, partly cleared by soft reset
  always @(posedge mclk) begin
    if (sys_rst) begin
      cfg_r <= 11'h001; // R5
    end else if (soft_rst) begin
      if (!lock) begin
        cfg_r[`FHR_CFG_FDIS] <= 1'b1; // R4
        cfg_r[`FHR_CFG_THR_HI:`FHR_CFG_THR_LO] <= `FHR_THR_RST; // R23
      end
    end else if (wr_cfg) begin
      cfg_r <= avs_writedata[10:0]; // R23
    end
  end

  // rate and precomp, deaf to soft reset
  always @(posedge mclk) begin
    if (sys_rst) begin
      rate_select_r <= `FHR_RATE_RST; // R15
      no_precomp_flag_r <= 1'b0;
    end else if (wr_rate) begin
      rate_select_r <= avs_writedata[1:0]; // R16 R24
      if (lay == `FHR_LAY_THIRD)
        no_precomp_flag_r <= avs_writedata[`FHR_RATE_NO_PRECOMP_FLAG]; // R17
    end else if (wr_rpsel) begin
      rate_select_r <= avs_writedata[1:0]; // R16
    end
  end

  // service request pacing
  always @* begin
    if (core_dir)
      req_cond = cnt_r >= thr1;
    else
      req_cond = room >= thr1;
    req_nxt = req_on_r;
    if (!exec || soft_rst) begin
      req_nxt = 1'b0;
    end else if (req_on_r) begin
      if (core_dir ? (cnt_nxt == 5'd0) : (cnt_nxt == cap))
        req_nxt = 1'b0;
    end else if (req_cond) begin
      req_nxt = 1'b1;
    end
  end

  // quiet gap after each non-burst transfer
  always @(posedge mclk) begin
    if (sys_rst) begin
      gap_r <= 5'd0;
    end else if (!burst && xfer) begin
      gap_r <= GAP_CYC; // R7
    end else if (gap_r != 5'd0) begin
      gap_r <= gap_r - 5'd1;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      req_on_r <= 1'b0;
      dma_request_line_r <= 1'b0;
    end else begin
      req_on_r <= req_nxt; // R6
      if (burst)
        dma_request_line_r <= req_nxt; // R6
      else
        dma_request_line_r <= req_nxt && (gap_r == 5'd0) && !xfer; // R7
    end
  end

  // diagnostic view by layout
  always @* begin
    case (lay)
      `FHR_LAY_AT: diag_v = {dsk_chg, 7'h00}; // R11
      `FHR_LAY_SEC: diag_v = {dsk_chg, 4'hF, rate_select_r,
                             fhr_low_rate(rate_select_r)}; // R13
      `FHR_LAY_THIRD: diag_v = {!dsk_chg, 3'h0, dma_gate_enable,
                               no_precomp_flag_r, rate_select_r}; // R14
      default: diag_v = {dsk_chg, 7'h00};
    endcase
  end

  // read mux, unmapped or write-only reads zero
  always @* begin
    rd_nxt = 32'h00000000;
    case (avs_address)
      `FHR_A_DATA: rd_nxt = {24'h000000, mem_r[rdp_r]};
      `FHR_A_MSTAT: rd_nxt = {19'h00000, cnt_r, request_for_master, core_dir, 6'h00}; // R22
      `FHR_A_DIAG: rd_nxt = {24'h000000, diag_v}; // R12
      `FHR_A_CFG: rd_nxt = {21'h000000, cfg_r};
      `FHR_A_ST0: rd_nxt = (core_phase == `FHR_PH_RES) ?
                           {24'h000000, st0_byte_r} : 32'h00000000; // R18
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // one wait cycle per access, then acknowledge
  always @(posedge mclk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= rd_nxt;
    end
  end

  // status toward the core, status byte only in result phase
  always @(posedge mclk) begin
    if (sys_rst) begin
      fifo_enable_r <= 1'b0;
      fifo_trigger_level_r <= 4'h0;
      st0_byte_r <= 8'h00;
    end else begin
      fifo_enable_r <= use_fifo; // R3
      fifo_trigger_level_r <= thr_eff; // R10
      st0_byte_r <= res_ph ? st0_v : 8'h00; // R18 R19 R20 R21
    end
  end

endmodule
`default_nettype wire

// [test/fhr_regs_checker.sv]
// assertions on the host register bank ports
`timescale 1ns/1ps
`default_nettype none
module fhr_chk (
  input wire mclk,
  input wire sys_rst,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  input wire [1:0] core_phase,
  input wire [1:0] rate_select_r,
  input wire fifo_enable_r,
  input wire [3:0] fifo_trigger_level_r,
  input wire [7:0] st0_byte_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_ack_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_ack_soon; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ack_soon: assert property (p_ack_soon) else $error("ack late");
  property p_rate_rst; $fell(sys_rst) |-> rate_select_r == 2'h2; endproperty
  a_rate_rst: assert property (p_rate_rst) else $error("rate reset wrong");
  property p_fifo_rst; $fell(sys_rst) |-> !fifo_enable_r && fifo_trigger_level_r == 4'h0; endproperty
  a_fifo_rst: assert property (p_fifo_rst) else $error("fifo reset wrong");
  property p_bypass; (core_phase != 2'h1) [*3] |-> !fifo_enable_r; endproperty
  a_bypass: assert property (p_bypass) else $error("fifo used outside execution");
  property p_thr0; !fifo_enable_r |-> fifo_trigger_level_r == 4'h0; endproperty
  a_thr0: assert property (p_thr0) else $error("threshold nonzero with fifo off");
  property p_st0; (core_phase != 2'h2) [*3] |-> st0_byte_r == 8'h0; endproperty
  a_st0: assert property (p_st0) else $error("status byte outside result phase");
  property p_rate_wr;
    avs_write && !avs_waitrequest && (avs_address == 3'h3 || avs_address == 3'h5)
      |=> rate_select_r == $past(avs_writedata[1:0]);
  endproperty
  a_rate_wr: assert property (p_rate_wr) else $error("rate not from latest write");
endmodule
bind fhr_regs fhr_chk u_chk (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_waitrequest, .core_phase, .rate_select_r, .fifo_enable_r, .fifo_trigger_level_r, .st0_byte_r);
`default_nettype wire

// [test/fhr_core_model.sv]
// behavioural controller core facing the register bank
`timescale 1ns/1ps
`default_nettype none
module fhr_core_model (
  input wire logic mclk,
  output logic [1:0] core_phase,
  output logic core_dir,
  output logic core_push,
  output logic [7:0] core_push_data,
  output logic core_pop
);
  initial begin
    core_phase = 2'h0;
    core_dir = 1'b0;
    core_push = 1'b0;
    core_push_data = 8'hA5;
    core_pop = 1'b0;
  end
  task set_phase(input logic [1:0] p, input logic d);
    @(posedge mclk);
    core_phase <= p;
    core_dir <= d;
  endtask
  task push_byte(input logic [7:0] b);
    @(posedge mclk);
    core_push_data <= b;
    core_push <= 1'b1;
    @(posedge mclk);
    core_push <= 1'b0;
  endtask
  task pop_byte;
    @(posedge mclk);
    core_pop <= 1'b1;
    @(posedge mclk);
    core_pop <= 1'b0;
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// [test/test_fhr_regs.sv]
// self-checking bench for the host register bank
`timescale 1ns/1ps
`default_nettype none
module test_fhr_regs;
  logic mclk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, core_push, core_pop, core_dir;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, core_pop_valid_r, core_room_r, no_precomp_flag_r, fifo_enable_r, dma_request_line_r;
  logic seek_complete = 0, equipment_fault = 0, head_select_pin = 0, disk_changed_input = 0, dma_gate_enable = 1;
  logic [1:0] core_phase, termination_code = 2'h0, drive_code = 2'h3, rate_select_r;
  logic [7:0] core_push_data, core_pop_data_r, st0_byte_r;
  logic [3:0] fifo_trigger_level_r;
  int err_count = 0, n_compared = 0, cyc = 0;
  always #20 mclk = ~mclk;
  fhr_regs DUT (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .core_phase, .core_dir, .core_push, .core_push_data, .core_pop, .core_pop_data_r,
    .core_pop_valid_r, .core_room_r, .termination_code, .seek_complete, .equipment_fault, .head_select_pin,
    .drive_code, .disk_changed_input, .dma_gate_enable, .rate_select_r, .no_precomp_flag_r, .fifo_enable_r,
    .fifo_trigger_level_r, .dma_request_line_r, .st0_byte_r);
  fhr_core_model u_core (.mclk, .core_phase, .core_dir, .core_push, .core_push_data, .core_pop);
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest seen low
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task wr(input logic [2:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    disk_changed_input <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(rate_select_r, 32'h2);
    rd(3'h4, 32'h001);
    rd(3'h2, 32'h80);
    rd(3'h3, 32'h0);
    $display("test reset done");
    wr(3'h4, 32'h201);
    rd(3'h2, 32'hFD);
    wr(3'h4, 32'h401);
    wr(3'h3, 32'hFF);
    chk(rate_select_r, 32'h3);
    chk(no_precomp_flag_r, 32'h1);
    rd(3'h2, 32'h0F);
    wr(3'h5, 32'h1);
    rd(3'h2, 32'h0D);
    $display("test layouts done");
    wr(3'h4, 32'h416);
    wr(3'h7, 32'h1);
    rd(3'h4, 32'h416);
    rd(3'h2, 32'h0D);
    wr(3'h4, 32'h414);
    wr(3'h7, 32'h1);
    rd(3'h4, 32'h401);
    chk(rate_select_r, 32'h1);
    $display("test soft reset done");
    seek_complete <= 1'b1;
    head_select_pin <= 1'b1;
    rd(3'h6, 32'h0);
    u_core.set_phase(2'h2, 1'b0);
    for (int i = 0; i < 4; i++) begin
      termination_code <= i[1:0];
      equipment_fault <= i[0];
      repeat (2) @(posedge mclk);
      rd(3'h6, {24'h0, i[1:0], 1'b1, i[0], 4'h7});
    end
    u_core.set_phase(2'h2, 1'b1);
    u_core.push_byte(8'hC3);
    rd(3'h1, 32'h1C0);
    rd(3'h0, 32'hC3);
    u_core.set_phase(2'h0, 1'b0);
    rd(3'h6, 32'h0);
    rd(3'h1, 32'h80);
    wr(3'h0, 32'h5A);
    chk(core_room_r, 32'h0);
    u_core.pop_byte();
    chk(core_pop_data_r, 32'h5A);
    chk(core_room_r, 32'h1);
    $display("test status and data done");
    wr(3'h4, 32'h444);
    u_core.set_phase(2'h1, 1'b1);
    u_core.push_byte(8'h11);
    u_core.push_byte(8'h22);
    chk(fifo_enable_r, 32'h1);
    chk(fifo_trigger_level_r, 32'h1);
    while (dma_request_line_r !== 1'b1) @(posedge mclk);
    rd(3'h0, 32'h11);
    chk(dma_request_line_r, 32'h1);
    rd(3'h0, 32'h22);
    chk(dma_request_line_r, 32'h0);
    u_core.set_phase(2'h0, 1'b0);
    $display("test execution burst done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
